// >>> shared/gfsc_pkg.sv
// constants, tables and helper functions for the gap-fill scale factor stage
// assumes one clock domain shared with the upstream spectrum source
package gfsc_pkg;

  // ******************************************************************
  // widths and limits
  // ******************************************************************
  localparam int LINE_W = 11;
  localparam int REAL_W = 16;
  localparam int POW_W = 16;
  localparam int NUM_MODES = 13;
  localparam int MAX_EDGES = 11;
  localparam int MAX_TILES = 4;
  localparam int NUM_W = 64;
  localparam int DEN_W = 32;
  localparam logic [6:0] FACTOR_MAX = 7'h5B;
  localparam int LHS_SHIFT = 24;
  localparam logic [16:0] MANT_Q1 = 17'h13070;
  localparam logic [16:0] MANT_Q3 = 17'h1AE8A;

  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [3:0] CTRL_MODE_RESET = 4'h0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_DEP_BIT = 2;
  localparam int ST_TRANS_BIT = 3;
  localparam int ST_FX_LSB = 4;
  localparam int ST_WLEN_LSB = 16;

  // ******************************************************************
  // modes and tables
  // ******************************************************************
  typedef enum logic [1:0] {FX_100, FX_125, FX_050} gfsc_fx_type;

  localparam logic [10:0] LONG_WB = 11'h140;
  localparam logic [10:0] LONG_SWB = 11'h280;
  localparam logic [10:0] LONG_FB = 11'h3C0;
  localparam logic [3:0] FIRST_SWB = 4'h1;
  localparam logic [3:0] FIRST_FB = 4'h7;

  localparam logic [10:0] EDGE_TAB [NUM_MODES][MAX_EDGES] = '{
    '{11'h0A4, 11'h0BA, 11'h0F2, 11'h140, 11'h140, 11'h140, 11'h140, 11'h140, 11'h140, 11'h140, 11'h140},
    '{11'h0C8, 11'h142, 11'h1BC, 11'h236, 11'h236, 11'h236, 11'h236, 11'h236, 11'h236, 11'h236, 11'h236},
    '{11'h100, 11'h120, 11'h148, 11'h178, 11'h1B0, 11'h1F0, 11'h236, 11'h236, 11'h236, 11'h236, 11'h236},
    '{11'h100, 11'h120, 11'h148, 11'h178, 11'h1B0, 11'h1F0, 11'h240, 11'h280, 11'h280, 11'h280, 11'h280},
    '{11'h100, 11'h11C, 11'h13E, 11'h166, 11'h192, 11'h1C2, 11'h1FC, 11'h240, 11'h280, 11'h280, 11'h280},
    '{11'h100, 11'h11C, 11'h13E, 11'h166, 11'h192, 11'h1C2, 11'h1FC, 11'h240, 11'h280, 11'h280, 11'h280},
    '{11'h200, 11'h216, 11'h240, 11'h280, 11'h280, 11'h280, 11'h280, 11'h280, 11'h280, 11'h280, 11'h280},
    '{11'h100, 11'h120, 11'h148, 11'h178, 11'h1B0, 11'h1F0, 11'h240, 11'h280, 11'h2D0, 11'h320, 11'h320},
    '{11'h100, 11'h11C, 11'h13E, 11'h166, 11'h192, 11'h1C2, 11'h1FC, 11'h240, 11'h280, 11'h2D0, 11'h320},
    '{11'h100, 11'h11C, 11'h13E, 11'h166, 11'h192, 11'h1C2, 11'h1FC, 11'h240, 11'h280, 11'h2D0, 11'h320},
    '{11'h200, 11'h248, 11'h290, 11'h2D8, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320},
    '{11'h280, 11'h2D0, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320},
    '{11'h280, 11'h2D0, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320, 11'h320}
  };
  localparam logic [3:0] BAND_COUNT_TAB [NUM_MODES] = '{
    4'h3, 4'h3, 4'h6, 4'h7, 4'h8, 4'h8, 4'h3, 4'h9, 4'hA, 4'hA, 4'h4, 4'h2, 4'h2};
  localparam logic [6:0] MIN_SRC_TAB [NUM_MODES] = '{
    7'h1E, 7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h40, 7'h20, 7'h20, 7'h20, 7'h40, 7'h40, 7'h40};
  localparam logic [NUM_MODES-1:0] HIGH_RATE_MASK = 13'h1C40;

  // tile word: kind[12:11] (0 fixed, 1 twice-first-minus-last, 2 tenth-minus-ninth),
  // first edge index [10:7], fixed source offset before rescale [6:0]
  localparam logic [2:0] TILE_COUNT_TAB [NUM_MODES] = '{
    3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h3, 3'h1, 3'h3, 3'h4, 3'h4, 3'h1, 3'h1, 3'h1};
  localparam logic [12:0] TILE_TAB [NUM_MODES][MAX_TILES] = '{
    '{13'h0000, 13'h0100, 13'h0000, 13'h0000},
    '{13'h0000, 13'h00A0, 13'h012E, 13'h0000},
    '{13'h0000, 13'h0220, 13'h0000, 13'h0000},
    '{13'h0000, 13'h0230, 13'h0340, 13'h0000},
    '{13'h0000, 13'h0220, 13'h03C0, 13'h0000},
    '{13'h0000, 13'h0220, 13'h03C0, 13'h0000},
    '{13'h0800, 13'h0000, 13'h0000, 13'h0000},
    '{13'h0000, 13'h0200, 13'h0380, 13'h0000},
    '{13'h0000, 13'h0220, 13'h0300, 13'h1480},
    '{13'h0000, 13'h0220, 13'h0300, 13'h1480},
    '{13'h0800, 13'h0000, 13'h0000, 13'h0000},
    '{13'h0800, 13'h0000, 13'h0000, 13'h0000},
    '{13'h0800, 13'h0000, 13'h0000, 13'h0000}
  };

  // edge_rescale: line index times the transition factor, floored
  function automatic logic [10:0] edge_rescale(logic [10:0] t, gfsc_fx_type f);
    case (f)
      FX_125: edge_rescale = t + (t >> 2);
      FX_050: edge_rescale = t >> 1;
      default: edge_rescale = t;
    endcase
  endfunction

endpackage

// >>> shared/gfsc_quant_if.sv
// handshake between the band sequencer and the factor quantiser
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface gfsc_quant_if;
  logic start;
  logic [63:0] num;
  logic [31:0] den;
  logic done;
  logic [6:0] factor;
  modport ctrl(output start, output num, output den, input done, input factor);
  modport unit(input start, input num, input den, output done, output factor);
endinterface

// >>> rtl/gfsc_quant.sv
// factor quantiser: largest g in 0..91 with 256*num >= den * 2^((2g-1)/4)
// assumes start is a one-cycle pulse, never raised while busy
`timescale 1ns/1ps
module gfsc_quant
  import gfsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and answer
  gfsc_quant_if.unit q
);

  typedef struct packed {
    logic busy;
    logic [6:0] g;
    logic [63:0] num;
    logic [31:0] den;
    logic done;
    logic [6:0] factor;
  } gfsc_qstate_type;

  gfsc_qstate_type r_q, r_d;
  logic [7:0] expQ;
  logic [48:0] prod;
  logic [111:0] lhs;
  logic [111:0] rhs;

  // ******************************************************************
  // one threshold test per cycle
  // ******************************************************************
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    expQ = {r_q.g, 1'b1};
    prod = 49'(r_q.den) * 49'(expQ[1] ? MANT_Q3 : MANT_Q1);
    lhs = 112'(r_q.num) << LHS_SHIFT;
    rhs = 112'(prod) << expQ[7:2];
    if (!r_q.busy) begin
      if (q.start) begin
        r_d.busy = 1'b1;
        r_d.g = 7'h00;
        r_d.num = q.num;
        r_d.den = q.den;
      end
    end else if (r_q.g == FACTOR_MAX || lhs < rhs) begin
      // floor at 0 and ceiling at 91 fall out of the search bounds
      r_d.busy = 1'b0;
      r_d.done = 1'b1;
      r_d.factor = r_q.g;
    end else begin
      r_d.g = r_q.g + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q.done = r_q.done;
  assign q.factor = r_q.factor;

endmodule

// >>> rtl/gfsc_core.sv
// gap-fill scale factor stage: per frame, per band energy sums and factors
// assumes spectrum reads answer one cycle after the address is shown
//
// Summary of operation
// - only listed flag combinations; pick transition factor
// - window length from mode and flags
// - second of two short frames is dependent unless flagged independent
// - one factor per band, every accepted frame
// - target energy is root-mean power over band
// - source energies read through mapped source lines
// - band edges rescaled before any summation
// - real path factor from real energy only
// - clamped factors passed to downstream coder
// - edges from per-mode long-window table
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module gfsc_core
  import gfsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // frame flags from upstream
  input wire logic frameStart,
  input wire logic powerAvail,
  input wire logic frame_has_transient,
  input wire logic short_window_frame,
  input wire logic long_window_frame,
  input wire logic predictive_to_transform_switch,
  input wire logic independent_frame,
  // spectrum read ports
  output logic [10:0] lineAddr,
  output logic [10:0] srcAddr,
  input wire logic signed [15:0] lineReal,
  input wire logic [15:0] linePower,
  input wire logic signed [15:0] srcReal,
  input wire logic [15:0] srcPower,
  // factors to the arithmetic coder
  output logic factorValid,
  output logic [3:0] factorBand,
  output logic [6:0] factorValue,
  output logic frameDone,
  output logic [10:0] windowLen,
  output logic dependentFrame
);

  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_DRAIN, S_WAITQ} gfsc_state_type;

  typedef struct packed {
    gfsc_state_type st;
    logic [3:0] ctrlMode;
    logic [3:0] mode;
    gfsc_fx_type fx;
    logic powerOn;
    logic prevShort;
    logic depFrame;
    logic comboErr;
    logic transient;
    logic [3:0] band;
    logic [10:0] tb;
    logic [10:0] lineAddr;
    logic [10:0] srcAddr;
    logic issue;
    logic issueD;
    logic [39:0] sumRt;
    logic [39:0] sumRs;
    logic [23:0] sumPt;
    logic [23:0] sumPs;
    logic qStart;
    logic [63:0] qNum;
    logic [31:0] qDen;
    logic factorValid;
    logic [3:0] factorBand;
    logic [6:0] factorValue;
    logic frameDone;
    logic [10:0] windowLen;
    logic [31:0] rdata;
  } gfsc_core_type;

  gfsc_core_type r_q, r_d;
  gfsc_quant_if qb();
  logic signed [31:0] sqT;
  logic signed [31:0] sqS;
  logic [10:0] edgeLo;
  logic [10:0] edgeHi;
  logic [7:0] bandWidth;
  logic legal;
  logic highRate;
  logic [3:0] modeIn;
  gfsc_fx_type fxIn;
  logic [10:0] longLen;

  gfsc_quant u_quant (
    .clk(clk),
    .rst_n(rst_n),
    .q(qb.unit)
  );

  // ******************************************************************
  // edge and source line lookup
  // ******************************************************************
  function automatic logic [10:0] edgeAt(logic [3:0] m, gfsc_fx_type f, logic [3:0] k);
    edgeAt = edge_rescale(EDGE_TAB[m][k], f);
  endfunction

  function automatic logic [10:0] srcMap(logic [3:0] m, gfsc_fx_type f, logic [10:0] x);
    logic [12:0] tile;
    logic [10:0] base;
    logic [10:0] offs;
    logic [3:0] bandCnt;
    tile = TILE_TAB[m][0];
    bandCnt = BAND_COUNT_TAB[m];
    for (int i = 1; i < MAX_TILES; i++) begin
      if (3'(i) < TILE_COUNT_TAB[m] && x >= edgeAt(m, f, TILE_TAB[m][i][10:7])) begin
        tile = TILE_TAB[m][i];
      end
    end
    base = edgeAt(m, f, tile[10:7]);
    case (tile[12:11])
      2'h1: offs = (edgeAt(m, f, 4'h0) << 1) - edgeAt(m, f, bandCnt);
      2'h2: offs = edgeAt(m, f, 4'h9) - edgeAt(m, f, 4'h8);
      default: offs = edge_rescale(11'(tile[6:0]), f);
    endcase
    srcMap = 11'(MIN_SRC_TAB[m]) + offs + (x - base);
  endfunction

  // ******************************************************************
  // frame acceptance
  // ******************************************************************
  always_comb begin
    modeIn = r_q.ctrlMode;
    highRate = (modeIn < 4'(NUM_MODES)) && HIGH_RATE_MASK[modeIn];
    legal = (modeIn < 4'(NUM_MODES)) && (short_window_frame ^ long_window_frame)
            && (!short_window_frame || highRate);
    if (short_window_frame) begin
      fxIn = FX_050;
    end else if (predictive_to_transform_switch && !highRate) begin
      fxIn = FX_125;
    end else begin
      fxIn = FX_100;
    end
    if (modeIn >= FIRST_FB) begin
      longLen = LONG_FB;
    end else if (modeIn >= FIRST_SWB) begin
      longLen = LONG_SWB;
    end else begin
      longLen = LONG_WB;
    end
  end

  // ******************************************************************
  // band sequencer
  // ******************************************************************
  always_comb begin
    r_d = r_q;
    r_d.issue = 1'b0;
    r_d.issueD = r_q.issue;
    r_d.qStart = 1'b0;
    r_d.factorValid = 1'b0;
    r_d.frameDone = 1'b0;
    r_d.rdata = 32'h0000_0000;
    edgeLo = edgeAt(r_q.mode, r_q.fx, r_q.band);
    edgeHi = edgeAt(r_q.mode, r_q.fx, r_q.band + 4'h1);
    bandWidth = 8'(edgeHi - edgeLo);
    sqT = lineReal * lineReal;
    sqS = srcReal * srcReal;
    // data for the address shown last cycle
    if (r_q.issueD) begin
      r_d.sumRt = r_q.sumRt + 40'(unsigned'(sqT));
      r_d.sumRs = r_q.sumRs + 40'(unsigned'(sqS));
      r_d.sumPt = r_q.sumPt + 24'(linePower);
      r_d.sumPs = r_q.sumPs + 24'(srcPower);
    end
    case (r_q.st)
      S_IDLE: begin
        if (frameStart) begin
          if (!legal) begin
            r_d.comboErr = 1'b1;
          end else begin
            r_d.mode = modeIn;
            r_d.fx = fxIn;
            r_d.powerOn = powerAvail;
            r_d.transient = frame_has_transient;
            r_d.depFrame = short_window_frame && r_q.prevShort && !independent_frame;
            r_d.prevShort = short_window_frame;
            r_d.windowLen = edge_rescale(longLen, fxIn);
            r_d.band = 4'h0;
            r_d.tb = edgeAt(modeIn, fxIn, 4'h0);
            r_d.sumRt = '0;
            r_d.sumRs = '0;
            r_d.sumPt = '0;
            r_d.sumPs = '0;
            r_d.st = S_SCAN;
          end
        end
      end
      S_SCAN: begin
        r_d.lineAddr = r_q.tb;
        r_d.srcAddr = srcMap(r_q.mode, r_q.fx, r_q.tb);
        r_d.issue = 1'b1;
        if (r_q.tb == edgeHi - 11'h001) begin
          r_d.st = S_DRAIN;
        end else begin
          r_d.tb = r_q.tb + 11'h001;
        end
      end
      S_DRAIN: begin
        if (!r_q.issue && !r_q.issueD) begin
          if (!r_q.powerOn) begin
            r_d.qNum = 64'(r_q.sumRt);
            r_d.qDen = 32'(bandWidth);
          end else if (r_q.sumPs == 24'h000000) begin
            r_d.qNum = 64'h0;
            r_d.qDen = 32'h0000_0001;
          end else begin
            // (Et * Ereal / Ecplx)^2 with the common band width folded in
            r_d.qNum = 64'(r_q.sumPt) * 64'(r_q.sumRs);
            r_d.qDen = 32'(r_q.sumPs) * 32'(bandWidth);
          end
          r_d.qStart = 1'b1;
          r_d.st = S_WAITQ;
        end
      end
      S_WAITQ: begin
        if (qb.done) begin
          r_d.factorValid = 1'b1;
          r_d.factorBand = r_q.band;
          r_d.factorValue = qb.factor;
          r_d.sumRt = '0;
          r_d.sumRs = '0;
          r_d.sumPt = '0;
          r_d.sumPs = '0;
          if (r_q.band == BAND_COUNT_TAB[r_q.mode] - 4'h1) begin
            r_d.frameDone = 1'b1;
            r_d.st = S_IDLE;
          end else begin
            r_d.band = r_q.band + 4'h1;
            r_d.tb = edgeHi;
            r_d.st = S_SCAN;
          end
        end
      end
      default: r_d.st = S_IDLE;
    endcase
    // ****************************************************************
    // register port
    // ****************************************************************
    if (regWr && regAddr == REG_CTRL) begin
      r_d.ctrlMode = regWdata[CTRL_MODE_LSB +: 4];
    end
    // a rejection in the same cycle as the clear survives
    if (regWr && regAddr == REG_STATUS && regWdata[ST_ERR_BIT] && !(r_q.st == S_IDLE
        && frameStart && !legal)) begin
      r_d.comboErr = 1'b0;
    end
    if (regRd) begin
      if (regAddr == REG_CTRL) begin
        r_d.rdata[CTRL_MODE_LSB +: 4] = r_q.ctrlMode;
      end else if (regAddr == REG_STATUS) begin
        r_d.rdata[ST_BUSY_BIT] = (r_q.st != S_IDLE);
        r_d.rdata[ST_ERR_BIT] = r_q.comboErr;
        r_d.rdata[ST_DEP_BIT] = r_q.depFrame;
        r_d.rdata[ST_TRANS_BIT] = r_q.transient;
        r_d.rdata[ST_FX_LSB +: 2] = r_q.fx;
        r_d.rdata[ST_WLEN_LSB +: 11] = r_q.windowLen;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= '0;
      r_q.ctrlMode <= CTRL_MODE_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign qb.start = r_q.qStart;
  assign qb.num = r_q.qNum;
  assign qb.den = r_q.qDen;
  assign regRdata = r_q.rdata;
  assign lineAddr = r_q.lineAddr;
  assign srcAddr = r_q.srcAddr;
  assign factorValid = r_q.factorValid;
  assign factorBand = r_q.factorBand;
  assign factorValue = r_q.factorValue;
  assign frameDone = r_q.frameDone;
  assign windowLen = r_q.windowLen;
  assign dependentFrame = r_q.depFrame;

endmodule

// >>> tb/gfsc_monitor.sv
// assertion checker for the gap-fill scale factor stage
// assumes it is bound to gfsc_core and sees only its ports
`timescale 1ns/1ps
module gfsc_monitor
  import gfsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // frame and spectrum side
  input wire logic frameStart,
  input wire logic [10:0] lineAddr,
  // factor side
  input wire logic factorValid,
  input wire logic [3:0] factorBand,
  input wire logic [6:0] factorValue,
  input wire logic frameDone,
  input wire logic [10:0] windowLen,
  input wire logic dependentFrame
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ******************************************************************
  // band counter
  // ******************************************************************
  logic [3:0] nextBand_q;
  logic [3:0] nextBand_d;
  always_comb begin
    nextBand_d = nextBand_q;
    if (factorValid) begin
      nextBand_d = frameDone ? 4'h0 : factorBand + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nextBand_q <= 4'h0;
    end else begin
      nextBand_q <= nextBand_d;
    end
  end
  // ******************************************************************
  // properties
  // ******************************************************************
  sequence s_start;
    frameStart ##2 $changed(lineAddr);
  endsequence
  property p_factor_range;
    factorValid |-> factorValue <= FACTOR_MAX;
  endproperty
  property p_band_order;
    factorValid |-> factorBand == nextBand_q;
  endproperty
  property p_done_valid;
    frameDone |-> factorValid;
  endproperty
  property p_factor_hold;
    !factorValid |-> $stable(factorValue) && $stable(factorBand);
  endproperty
  property p_line_step;
    $changed(lineAddr) && !$past(frameStart, 2) |-> lineAddr == $past(lineAddr) + 11'h1;
  endproperty
  property p_win_at_start;
    $changed(windowLen) |-> $past(frameStart) &&
      windowLen inside {11'h140, 11'h190, 11'h280, 11'h320, 11'h3C0, 11'h4B0, 11'h1E0};
  endproperty
  property p_dep_at_start;
    $changed(dependentFrame) |-> $past(frameStart);
  endproperty
  property p_first_factor;
    s_start |-> ##[1:400] factorValid;
  endproperty
  a_factor_range: assert property (p_factor_range)
    else $error("factor above limit");
  a_band_order: assert property (p_band_order)
    else $error("band index out of order");
  a_done_valid: assert property (p_done_valid)
    else $error("frame done without factor");
  a_factor_hold: assert property (p_factor_hold)
    else $error("factor outputs moved between factors");
  a_line_step: assert property (p_line_step)
    else $error("target line address skipped");
  a_win_at_start: assert property (p_win_at_start)
    else $error("window length wrong or changed outside start");
  a_dep_at_start: assert property (p_dep_at_start)
    else $error("dependence changed outside start");
  a_first_factor: assert property (p_first_factor)
    else $error("no factor after frame start");
endmodule

// >>> tb/gfsc_spec_model.sv
// spectrum source model standing in for the upstream transform coder
// assumes the bench sets the per-frame shape before the frame starts
`timescale 1ns/1ps
module gfsc_spec_model (
  // clock
  input wire logic clk,
  // read addresses
  input wire logic [10:0] lineAddr,
  input wire logic [10:0] srcAddr,
  // read data, one cycle after the address
  output logic signed [15:0] lineReal,
  output logic [15:0] linePower,
  output logic signed [15:0] srcReal,
  output logic [15:0] srcPower
);
  // lines below the first edge are the source range, the rest target
  logic [10:0] edgeZero = 11'h000;
  logic signed [15:0] tgtReal = 16'h0000;
  logic signed [15:0] srcRealVal = 16'h0000;
  logic [15:0] tgtPower = 16'h0000;
  logic [15:0] srcPowerVal = 16'h0000;
  always @(posedge clk) begin
    lineReal <= (lineAddr < edgeZero) ? srcRealVal : tgtReal;
    linePower <= (lineAddr < edgeZero) ? srcPowerVal : tgtPower;
    srcReal <= (srcAddr < edgeZero) ? srcRealVal : tgtReal;
    srcPower <= (srcAddr < edgeZero) ? srcPowerVal : tgtPower;
  end
endmodule

// >>> tb/gfsc_core_tb.sv
// self-checking bench for the gap-fill scale factor stage
// assumes the spectrum model answers one cycle after each address
`timescale 1ns/1ps
module gfsc_core_tb
  import gfsc_pkg::*;
;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, frameStart = 1'b0;
  logic powerAvail = 1'b0, frame_has_transient = 1'b0, short_window_frame = 1'b0;
  logic long_window_frame = 1'b0, predictive_to_transform_switch = 1'b0;
  logic independent_frame = 1'b0, prevShort = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, d, r, s, seed = 32'h00013611;
  logic [10:0] lineAddr, srcAddr, windowLen;
  logic signed [15:0] lineReal, srcReal;
  logic [15:0] linePower, srcPower;
  logic factorValid, frameDone, dependentFrame;
  logic [3:0] factorBand;
  logic [6:0] factorValue;
  int failCount = 0, nCompared = 0, i, md;
  always #5 clk = ~clk;
  gfsc_core gfsc_core_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .frameStart(frameStart),
    .powerAvail(powerAvail), .frame_has_transient(frame_has_transient),
    .short_window_frame(short_window_frame), .long_window_frame(long_window_frame),
    .predictive_to_transform_switch(predictive_to_transform_switch),
    .independent_frame(independent_frame), .lineAddr(lineAddr), .srcAddr(srcAddr),
    .lineReal(lineReal), .linePower(linePower), .srcReal(srcReal), .srcPower(srcPower),
    .factorValid(factorValid), .factorBand(factorBand), .factorValue(factorValue),
    .frameDone(frameDone), .windowLen(windowLen), .dependentFrame(dependentFrame));
  gfsc_spec_model gfsc_spec_model_i (.clk(clk), .lineAddr(lineAddr), .srcAddr(srcAddr),
    .lineReal(lineReal), .linePower(linePower), .srcReal(srcReal), .srcPower(srcPower));
  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [6:0] exp_g(input real x);
    real v;
    int g;
    v = (x < 0.9) ? 0.9 : x;
    g = int'($floor(0.5 + 4.0 * $ln(v) / $ln(2.0)));
    g = (g < 0) ? 0 : (g > int'(FACTOR_MAX)) ? int'(FACTOR_MAX) : g;
    return g[6:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic run_frame(input int md, sh, sw, ind, tr, pw, rt, pt, rs, ps, lg = -1);
    int fx, e0, bandCnt, k, n;
    logic ok, hi, dep;
    logic [10:0] win, w0;
    real x;
    if (lg < 0) lg = !sh;
    hi = HIGH_RATE_MASK[md];
    ok = md <= 12 && sh != lg && (!sh || hi);
    fx = sh ? 2 : (sw && !hi) ? 1 : 0;
    win = 11'((md == 0) ? 320 : (md < 7) ? 640 : 960);
    win = (fx == 1) ? win + (win >> 2) : (fx == 2) ? win >> 1 : win;
    e0 = EDGE_TAB[md][0];
    e0 = (fx == 1) ? e0 * 5 / 4 : (fx == 2) ? e0 / 2 : e0;
    x = (rt < 0) ? -16.0 * rt : 16.0 * rt;
    if (pw) x = (ps == 0) ? 0.0 : 16.0 * $sqrt(pt) * ((rs < 0) ? -rs : rs) / $sqrt(ps);
    dep = sh && prevShort && !ind;
    bandCnt = ok ? BAND_COUNT_TAB[md] : 0;
    w0 = windowLen;
    reg_write(REG_CTRL, 32'(md));
    gfsc_spec_model_i.edgeZero = 11'(e0);
    gfsc_spec_model_i.tgtReal = 16'(rt);
    gfsc_spec_model_i.tgtPower = 16'(pt);
    gfsc_spec_model_i.srcRealVal = 16'(rs);
    gfsc_spec_model_i.srcPowerVal = 16'(ps);
    @(posedge clk);
    frameStart <= 1'b1;
    powerAvail <= pw[0];
    short_window_frame <= sh[0];
    long_window_frame <= lg[0];
    predictive_to_transform_switch <= sw[0];
    independent_frame <= ind[0];
    frame_has_transient <= tr[0];
    @(posedge clk);
    frameStart <= 1'b0;
    if (!ok) begin
      repeat (2) @(posedge clk);
      reg_read(REG_STATUS);
      check(d[1], 1'b1);
      check(windowLen, w0);
      reg_write(REG_STATUS, 32'h2);
      reg_read(REG_STATUS);
      check(d[1], 1'b0);
      return;
    end
    for (k = 0; k < bandCnt; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (!factorValid && n < 600);
      check(factorValid, 1'b1);
      if (factorValid !== 1'b1) endOfTest();
      check(factorBand, k);
      check(factorValue, exp_g(x));
      check(frameDone, k == bandCnt - 1);
    end
    check(windowLen, win);
    check(dependentFrame, dep);
    reg_read(REG_STATUS);
    check(d, {5'h0, win, 10'h0, 2'(fx), tr[0], dep, 2'b00});
    prevShort = sh[0];
  endtask
  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(REG_CTRL);
    check(d, 32'h0);
    reg_read(REG_STATUS);
    check(d, 32'h0);
    reg_read(8'h08);
    check(d, 32'h0);
    $display("test reset done");
    run_frame(13, 0, 0, 0, 0, 0, 5, 0, 0, 0);
    run_frame(3, 1, 0, 0, 0, 0, 5, 0, 0, 0);
    run_frame(6, 1, 0, 0, 0, 0, 5, 0, 0, 0, 1);
    run_frame(6, 0, 0, 0, 0, 0, 5, 0, 0, 0, 0);
    $display("test illegal combinations done");
    run_frame(0, 0, 1, 0, 1, 1, 0, 65535, -32768, 1);
    run_frame(7, 0, 0, 1, 0, 1, 9, 400, 100, 0);
    run_frame(12, 0, 1, 0, 0, 0, 0, 0, 0, 0);
    run_frame(11, 1, 0, 0, 0, 0, -1, 0, 0, 0);
    run_frame(10, 1, 0, 0, 0, 0, 300, 0, 0, 0);
    run_frame(10, 1, 0, 1, 1, 0, -77, 0, 0, 0);
    $display("test corner frames done");
    for (i = 0; i < 14; i++) begin
      r = rnd();
      s = rnd();
      md = r[3:0] % 13;
      run_frame(md, HIGH_RATE_MASK[md] & r[4], r[6], r[7], r[8], !HIGH_RATE_MASK[md] & r[5],
        $signed(s[15:0]), r[31:16], $signed(s[31:16]), r[23:9] % 512);
    end
    $display("test random frames done");
    endOfTest();
  end
endmodule
bind gfsc_core gfsc_monitor gfsc_monitor_i (.clk(clk), .rst_n(rst_n), .frameStart(frameStart),
  .lineAddr(lineAddr), .factorValid(factorValid), .factorBand(factorBand),
  .factorValue(factorValue), .frameDone(frameDone), .windowLen(windowLen),
  .dependentFrame(dependentFrame));
